// File: epi_map.svh
// Register offsets, field positions and reset values of the pin interrupt unit
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH
`define EPI_NUM_PINS 8
`define EPI_OFF_EVCTRL 8'h04
`define EPI_OFF_ENCLR 8'h08
`define EPI_OFF_ENSET 8'h0C
`define EPI_OFF_FLAG 8'h10
`define EPI_OFF_WAKE 8'h14
`define EPI_OFF_CONFIG 8'h18
`define EPI_OFF_MASK 8'h1C
`define EPI_SLOT_W 4
`define EPI_SENSE_W 3
`define EPI_FILT_BIT 3
`define EPI_SENSE_NONE 3'h0
`define EPI_SENSE_RISE 3'h1
`define EPI_SENSE_FALL 3'h2
`define EPI_SENSE_BOTH 3'h3
`define EPI_SENSE_HIGH 3'h4
`define EPI_SENSE_LOW 3'h5
`define EPI_RST8 8'h00
`define EPI_RST32 32'h0000_0000
`define EPI_RESP_OKAY 2'h0
`define EPI_RESP_SLVERR 2'h2
`endif

// File: epi_pin_detect.sv
// Per-pin synchroniser, majority filter and sense detector
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_pin_detect
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic pin_in,
   input wire logic [3:0] slot_in,
   output logic match_out
);
   import epi_pkg::*;

   logic [2:0] sync_ff;
   logic [2:0] nxt_sync;
   logic stable_ff;
   logic nxt_stable;
   logic [2:0] hist_ff;
   logic [2:0] nxt_hist;
   logic lvl_ff;
   logic nxt_lvl;
   logic prev_ff;
   logic nxt_prev;
   logic match_ff;
   logic nxt_match;
   logic vote;
   logic [2:0] sense;

   always_comb
   begin
      sense = slot_in[`EPI_SENSE_W-1:0];
      nxt_sync = {sync_ff[1:0], pin_in};
      // Change counts only when stages two and three agree
      nxt_stable = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : stable_ff;
      nxt_hist = {hist_ff[1:0], stable_ff};
      vote = (hist_ff[0] & hist_ff[1]) | (hist_ff[1] & hist_ff[2])
         | (hist_ff[0] & hist_ff[2]);
      nxt_lvl = slot_in[`EPI_FILT_BIT] ? vote : stable_ff;
      nxt_prev = lvl_ff;
      nxt_match = 1'b0;
      case (sense)
         `EPI_SENSE_RISE: nxt_match = lvl_ff & ~prev_ff;
         `EPI_SENSE_FALL: nxt_match = ~lvl_ff & prev_ff;
         `EPI_SENSE_BOTH: nxt_match = lvl_ff ^ prev_ff;
         `EPI_SENSE_HIGH: nxt_match = lvl_ff;
         `EPI_SENSE_LOW: nxt_match = ~lvl_ff;
         // None and reserved codes never detect
         default: nxt_match = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         sync_ff <= 3'h0;
         stable_ff <= 1'b0;
         hist_ff <= 3'h0;
         lvl_ff <= 1'b0;
         prev_ff <= 1'b0;
         match_ff <= 1'b0;
      end
      else
      begin
         sync_ff <= nxt_sync;
         stable_ff <= nxt_stable;
         hist_ff <= nxt_hist;
         lvl_ff <= nxt_lvl;
         prev_ff <= nxt_prev;
         match_ff <= nxt_match;
      end
   end

   assign match_out = match_ff;
endmodule : epi_pin_detect

// File: epi_pin_irq.sv
// External pin interrupt unit with AXI4-Lite register slave
`timescale 1ns/1ps
`include "epi_map.svh"
module epi_pin_irq
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] ext_irq_pin_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [7:0] pin_irq_req_out,
   output logic irq_out,
   output logic wake_req_out,
   output logic [7:0] pin_event_out
);
   import epi_pkg::*;

   epi_regs_t regs_ff;
   epi_regs_t nxt_regs;
   logic [7:0] match;
   logic [7:0] event_ff;
   logic [7:0] nxt_event;
   logic wake_ff;
   logic nxt_wake;
   logic irq_ff;
   logic nxt_irq;

   // Write channel state
   epi_wstate_t wst_ff;
   epi_wstate_t nxt_wst;
   logic aw_have_ff;
   logic nxt_aw_have;
   logic w_have_ff;
   logic nxt_w_have;
   logic [7:0] awaddr_ff;
   logic [7:0] nxt_awaddr;
   logic [31:0] wdata_ff;
   logic [31:0] nxt_wdata;
   logic [3:0] wstrb_ff;
   logic [3:0] nxt_wstrb;
   logic [1:0] bresp_ff;
   logic [1:0] nxt_bresp;

   // Read channel state
   logic rvalid_ff;
   logic nxt_rvalid;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] rresp_ff;
   logic [1:0] nxt_rresp;

   logic do_write;
   logic [7:0] wbyte;
   logic [7:0] flag_clr;
   logic [31:0] cfg_wr;

   genvar gi;
   generate
      for (gi = 0; gi < `EPI_NUM_PINS; gi++)
      begin : g_pin
         epi_pin_detect u_det
         (
            .clk_in(clk_in),
            .rst_in(rst_in),
            .pin_in(ext_irq_pin_in[gi]),
            .slot_in(regs_ff.cfg[gi*`EPI_SLOT_W +: `EPI_SLOT_W]),
            .match_out(match[gi])
         );
      end
   endgenerate

   assign s_axi_awready_out = (wst_ff == EPI_W_IDLE) && !aw_have_ff;
   assign s_axi_wready_out = (wst_ff == EPI_W_IDLE) && !w_have_ff;
   assign s_axi_arready_out = !rvalid_ff;

   always_comb
   begin
      nxt_wst = wst_ff;
      nxt_aw_have = aw_have_ff;
      nxt_w_have = w_have_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_wstrb = wstrb_ff;
      nxt_bresp = bresp_ff;
      do_write = 1'b0;
      case (wst_ff)
         EPI_W_IDLE:
         begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
               nxt_aw_have = 1'b1;
               nxt_awaddr = s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
               nxt_w_have = 1'b1;
               nxt_wdata = s_axi_wdata_in;
               nxt_wstrb = s_axi_wstrb_in;
            end
            if (aw_have_ff && w_have_ff)
            begin
               do_write = 1'b1;
               nxt_wst = EPI_W_RESP;
            end
         end
         EPI_W_RESP:
         begin
            if (s_axi_bready_in)
            begin
               nxt_wst = EPI_W_IDLE;
               nxt_aw_have = 1'b0;
               nxt_w_have = 1'b0;
            end
         end
         default: nxt_wst = EPI_W_IDLE;
      endcase
      // Only byte lane 0 carries the eight-pin registers
      wbyte = wstrb_ff[0] ? wdata_ff[7:0] : `EPI_RST8;
      for (int b = 0; b < 4; b++)
      begin
         cfg_wr[b*8 +: 8] = wstrb_ff[b] ? wdata_ff[b*8 +: 8]
            : regs_ff.cfg[b*8 +: 8];
      end
      nxt_regs = regs_ff;
      flag_clr = `EPI_RST8;
      if (do_write)
      begin
         nxt_bresp = `EPI_RESP_OKAY;
         if (awaddr_ff == `EPI_OFF_EVCTRL)
            nxt_regs.evout = wstrb_ff[0] ? wdata_ff[7:0] : regs_ff.evout;
         else if (awaddr_ff == `EPI_OFF_ENCLR)
            nxt_regs.ena = regs_ff.ena & ~wbyte;
         else if (awaddr_ff == `EPI_OFF_ENSET)
            nxt_regs.ena = regs_ff.ena | wbyte;
         else if (awaddr_ff == `EPI_OFF_FLAG)
            flag_clr = wbyte;
         else if (awaddr_ff == `EPI_OFF_WAKE)
            nxt_regs.wake = wstrb_ff[0] ? wdata_ff[7:0] : regs_ff.wake;
         else if (awaddr_ff == `EPI_OFF_CONFIG)
            nxt_regs.cfg = cfg_wr;
         else if (awaddr_ff == `EPI_OFF_MASK)
            nxt_regs.mask = wstrb_ff[0] ? wdata_ff[7:0] : regs_ff.mask;
         else
            nxt_bresp = `EPI_RESP_SLVERR;
      end
      // Set wins over clear in the same cycle
      nxt_regs.flag = (regs_ff.flag & ~flag_clr) | match;
      nxt_event = match & regs_ff.evout;
      nxt_wake = |(match & regs_ff.wake);
      nxt_irq = |(nxt_regs.flag & nxt_regs.ena & nxt_regs.mask);
   end

   always_comb
   begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata = rdata_ff;
      nxt_rresp = rresp_ff;
      if (rvalid_ff && s_axi_rready_in)
         nxt_rvalid = 1'b0;
      if (s_axi_arvalid_in && s_axi_arready_out)
      begin
         nxt_rvalid = 1'b1;
         nxt_rresp = `EPI_RESP_OKAY;
         // Upper bits zero-filled on all eight-pin registers
         if (s_axi_araddr_in == `EPI_OFF_EVCTRL)
            nxt_rdata = {24'h000000, regs_ff.evout};
         else if (s_axi_araddr_in == `EPI_OFF_ENCLR ||
            s_axi_araddr_in == `EPI_OFF_ENSET)
            nxt_rdata = {24'h000000, regs_ff.ena};
         else if (s_axi_araddr_in == `EPI_OFF_FLAG)
            nxt_rdata = {24'h000000, regs_ff.flag};
         else if (s_axi_araddr_in == `EPI_OFF_WAKE)
            nxt_rdata = {24'h000000, regs_ff.wake};
         else if (s_axi_araddr_in == `EPI_OFF_CONFIG)
            nxt_rdata = regs_ff.cfg;
         else if (s_axi_araddr_in == `EPI_OFF_MASK)
            nxt_rdata = {24'h000000, regs_ff.mask};
         else
         begin
            nxt_rdata = `EPI_RST32;
            nxt_rresp = `EPI_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         regs_ff <= '0;
         event_ff <= `EPI_RST8;
         wake_ff <= 1'b0;
         irq_ff <= 1'b0;
         wst_ff <= EPI_W_IDLE;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         awaddr_ff <= `EPI_RST8;
         wdata_ff <= `EPI_RST32;
         wstrb_ff <= 4'h0;
         bresp_ff <= `EPI_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= `EPI_RST32;
         rresp_ff <= `EPI_RESP_OKAY;
      end
      else
      begin
         regs_ff <= nxt_regs;
         event_ff <= nxt_event;
         wake_ff <= nxt_wake;
         irq_ff <= nxt_irq;
         wst_ff <= nxt_wst;
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rdata_ff <= nxt_rdata;
         rresp_ff <= nxt_rresp;
      end
   end

   assign s_axi_bvalid_out = (wst_ff == EPI_W_RESP);
   assign s_axi_bresp_out = bresp_ff;
   assign s_axi_rvalid_out = rvalid_ff;
   assign s_axi_rdata_out = rdata_ff;
   assign s_axi_rresp_out = rresp_ff;
   assign pin_irq_req_out = regs_ff.flag & regs_ff.ena;
   assign irq_out = irq_ff;
   assign wake_req_out = wake_ff;
   assign pin_event_out = event_ff;
endmodule : epi_pin_irq

// File: epi_pin_irq_props.sv
// Port checker for the pin interrupt unit
`timescale 1ns/1ps
module epi_pin_irq_props
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [7:0] pin_irq_req_out,
   input wire logic irq_out
);
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   a_reset_quiet: assert property ($fell(rst_in) |-> !s_axi_bvalid_out &&
      !s_axi_rvalid_out && !irq_out && pin_irq_req_out == 8'h00)
      else $error("outputs not idle after reset");
   a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
      s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write response late");
   a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out)
      else $error("write response dropped early");
   a_write_busy: assert property (s_axi_bvalid_out
      |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while response pending");
   a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out)
      else $error("read data late");
   a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)
      && $stable(s_axi_rresp_out))
      else $error("read data changed before taken");
   a_read_busy: assert property (s_axi_arready_out == !s_axi_rvalid_out)
      else $error("read address ready wrong");
   a_irq_cause: assert property (irq_out |-> (|pin_irq_req_out)
      || (|$past(pin_irq_req_out)))
      else $error("interrupt without pending request");
endmodule : epi_pin_irq_props

bind epi_pin_irq epi_pin_irq_props i_epi_pin_irq_props
(
   .clk_in(clk_in), .rst_in(rst_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
   .pin_irq_req_out(pin_irq_req_out), .irq_out(irq_out)
);

// File: epi_pin_model.sv
// Far-side pin driver for the pin interrupt unit
`timescale 1ns/1ps
module epi_pin_model
(
   input wire logic clk_in,
   input wire logic [7:0] lvl_in,
   output logic [7:0] pin_out
);
   // Pins follow the bench levels one clock later, on the edge
   always @(posedge clk_in)
   begin
      pin_out <= lvl_in;
   end
endmodule : epi_pin_model

// File: epi_pkg.sv
// Types shared by the pin interrupt unit
package epi_pkg;
   typedef struct packed
   {
      logic [7:0] ena;
      logic [7:0] flag;
      logic [7:0] wake;
      logic [7:0] evout;
      logic [7:0] mask;
      logic [31:0] cfg;
   } epi_regs_t;

   typedef enum logic [1:0]
   {
      EPI_W_IDLE,
      EPI_W_RESP
   } epi_wstate_t;
endpackage : epi_pkg

// File: tb_epi_pin_irq.sv
// Self-checking bench for the pin interrupt unit
`timescale 1ns/1ps
`include "epi_map.svh"
module tb_epi_pin_irq;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] lvl = 8'h00;
   logic [7:0] pins;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, wake;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] req, ev;
   logic [7:0] ev_acc = 8'h00;
   logic wk_acc = 1'b0;
   logic acc_clr = 1'b0;
   int n_fail = 0;
   int checked = 0;

   always #2 clk_in = ~clk_in;

   // Pulses are short, so gather them between checks
   always @(posedge clk_in)
   begin
      ev_acc <= acc_clr ? 8'h00 : ev_acc | ev;
      wk_acc <= acc_clr ? 1'b0 : wk_acc | wake;
   end

   epi_pin_model i_epi_pin_model
   (
      .clk_in(clk_in),
      .lvl_in(lvl),
      .pin_out(pins)
   );

   epi_pin_irq i_epi_pin_irq
   (
      .clk_in(clk_in), .rst_in(rst_in), .ext_irq_pin_in(pins),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .pin_irq_req_out(req), .irq_out(irq),
      .wake_req_out(wake), .pin_event_out(ev)
   );

   task results;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (i == 40)
      begin
         n_fail++;
         results();
      end
      chk("bresp", {30'h0, `EPI_RESP_OKAY}, {30'h0, bresp});
   endtask : wr

   task rd(input string what, input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er);
      int i;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 40; i++)
      begin
         @(posedge clk_in);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (i == 40)
      begin
         n_fail++;
         results();
      end
      chk(what, e, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd

   task settle;
      repeat (16) @(posedge clk_in);
   endtask : settle

   initial
   begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      rd("enset", `EPI_OFF_ENSET, 32'h0, `EPI_RESP_OKAY);
      rd("flag", `EPI_OFF_FLAG, 32'h0, `EPI_RESP_OKAY);
      rd("wake", `EPI_OFF_WAKE, 32'h0, `EPI_RESP_OKAY);
      rd("config", `EPI_OFF_CONFIG, 32'h0, `EPI_RESP_OKAY);
      rd("unmapped", 8'h20, 32'h0, `EPI_RESP_SLVERR);
      $display("reset test done");
      wr(`EPI_OFF_ENSET, 32'h0000_00A5);
      wr(`EPI_OFF_ENSET, 32'h0000_0000);
      rd("enset", `EPI_OFF_ENSET, 32'hA5, `EPI_RESP_OKAY);
      wr(`EPI_OFF_ENCLR, 32'h0000_0005);
      rd("enclr", `EPI_OFF_ENCLR, 32'hA0, `EPI_RESP_OKAY);
      rd("enset", `EPI_OFF_ENSET, 32'hA0, `EPI_RESP_OKAY);
      // Lane 0 unstrobed, so the set write must change nothing
      wstrb <= 4'hE;
      wr(`EPI_OFF_ENSET, 32'h0000_00FF);
      wstrb <= 4'hF;
      rd("enset lane", `EPI_OFF_ENSET, 32'hA0, `EPI_RESP_OKAY);
      $display("enable test done");
      // Pin slots: rise, fall, both, high, low, none, reserved, filtered rise
      wr(`EPI_OFF_CONFIG, 32'h9605_4321);
      rd("config", `EPI_OFF_CONFIG, 32'h9605_4321, `EPI_RESP_OKAY);
      wr(`EPI_OFF_EVCTRL, 32'h0000_0004);
      rd("evctrl", `EPI_OFF_EVCTRL, 32'h04, `EPI_RESP_OKAY);
      wr(`EPI_OFF_WAKE, 32'h0000_0002);
      rd("wake set", `EPI_OFF_WAKE, 32'h02, `EPI_RESP_OKAY);
      settle();
      wr(`EPI_OFF_FLAG, 32'h0000_00FF);
      acc_clr <= 1'b1;
      rd("flag low", `EPI_OFF_FLAG, 32'h10, `EPI_RESP_OKAY);
      acc_clr <= 1'b0;
      @(posedge clk_in);
      lvl <= 8'hFF;
      settle();
      rd("flag rise", `EPI_OFF_FLAG, 32'h9D, `EPI_RESP_OKAY);
      chk("req", 32'h80, {24'h0, req});
      chk("events", 32'h04, {24'h0, ev_acc});
      chk("wake early", 32'h0, {31'h0, wk_acc});
      wr(`EPI_OFF_FLAG, 32'h0000_0081);
      rd("flag w1c", `EPI_OFF_FLAG, 32'h1C, `EPI_RESP_OKAY);
      @(posedge clk_in);
      lvl <= 8'h00;
      settle();
      rd("flag fall", `EPI_OFF_FLAG, 32'h1E, `EPI_RESP_OKAY);
      chk("wake", 32'h1, {31'h0, wk_acc});
      $display("sense test done");
      wr(`EPI_OFF_ENSET, 32'h0000_0002);
      chk("req bit", 32'h02, {24'h0, req});
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`EPI_OFF_MASK, 32'h0000_0002);
      rd("mask", `EPI_OFF_MASK, 32'h02, `EPI_RESP_OKAY);
      repeat (2) @(posedge clk_in);
      chk("irq", 32'h1, {31'h0, irq});
      wr(`EPI_OFF_FLAG, 32'h0000_0002);
      repeat (2) @(posedge clk_in);
      chk("irq cleared", 32'h0, {31'h0, irq});
      chk("req cleared", 32'h0, {24'h0, req});
      $display("interrupt test done");
      // Mid-run reset must clear what software set
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd("enset again", `EPI_OFF_ENSET, 32'h0, `EPI_RESP_OKAY);
      rd("mask again", `EPI_OFF_MASK, 32'h0, `EPI_RESP_OKAY);
      chk("irq reset", 32'h0, {31'h0, irq});
      $display("second reset test done");
      results();
   end
endmodule : tb_epi_pin_irq
